// file: core/tqsl_top.sv
// Torque-mode speed limit selection, speed-limited and torque reach flags
// What this block does
// - Speed limit clamps motor speed only in torque control mode.
// - Source 0 internal pair, 1 reserved, 2 input-selected single limit.
// - Source 0: positive limit bounds forward, negative limit bounds reverse.
// - Source 2: limit select input chooses which single limit parameter acts.
// - Input inactive uses limit 1; input active uses limit 2.
// - Both speed limits accept 0..6000 rpm, default 3000.
// - Speed-limited flag rises after speed exceeds limit for qualify time.
// - Speed-limited flag evaluated only in torque mode, else inactive.
// - Active flag means speed loop regulated against the limit.
// - Reach rises at |torque| >= ref+assert, falls at |torque| < ref+release.
// - Assert and release thresholds are offsets on the reach reference.
// - Reach reference spans 0..300.0 percent, resets to 0.
// - Assert/release offsets span 0..300.0 percent, default 20.0 and 10.0.
// - Torque percentages scaled so 100 percent equals rated torque.
// - Comparison uses absolute torque reference, readable as monitor.
`timescale 1ns/1ps
module tqsl_top (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Drive samples
    input wire tqsl_pkg::tqsl_drive_s drive,
    // Limits and flags
    output tqsl_pkg::tqsl_limit_s limit,
    output logic speed_limited_output,
    output logic torque_reach_output
);
    import tqsl_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [15:0] speed_limit_source_select, next_speed_limit_source_select;
    logic [15:0] positive_speed_limit, next_positive_speed_limit;
    logic [15:0] negative_speed_limit, next_negative_speed_limit;
    logic [15:0] torque_reach_reference, next_torque_reach_reference;
    logic [15:0] torque_reach_assert_offset, next_torque_reach_assert_offset;
    logic [15:0] torque_reach_release_offset, next_torque_reach_release_offset;
    logic [15:0] speed_limited_qualify_time, next_speed_limited_qualify_time;
    logic [15:0] actual_torque_reference_monitor, next_actual_torque_reference_monitor;
    logic [15:0] qual_ms, next_qual_ms;
    logic [31:0] qual_tick, next_qual_tick;
    logic next_speed_limited_output;
    logic next_torque_reach_output;
    tqsl_limit_s next_limit;
    logic have_aw, next_have_aw;
    logic have_w, next_have_w;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_awready, next_wready, next_bvalid;
    logic next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;

    // ------------------------------------------------------------
    // Combinational helpers
    // ------------------------------------------------------------
    logic [15:0] abs_speed, abs_torque;
    logic [15:0] lim_pos, lim_neg, lim_dir;
    logic [16:0] reach_on, reach_off;
    logic over_limit;
    logic write_go;

    // Limit selection per source and direction
    always_comb begin
        abs_speed = drive.motor_speed[15] ? 16'(-drive.motor_speed) : drive.motor_speed;
        abs_torque = drive.torque_reference[15] ? 16'(-drive.torque_reference)
                                                : drive.torque_reference;
        if (speed_limit_source_select == SRC_BY_INPUT) begin
            lim_pos = drive.limit_select_input ? negative_speed_limit
                                               : positive_speed_limit;
            lim_neg = lim_pos;
        end else begin
            // Reserved and unknown codes fall back to the internal pair
            lim_pos = positive_speed_limit;
            lim_neg = negative_speed_limit;
        end
        lim_dir = drive.motor_speed[15] ? lim_neg : lim_pos;
        over_limit = abs_speed > lim_dir;
        reach_on = {1'b0, torque_reach_reference} + {1'b0, torque_reach_assert_offset};
        reach_off = {1'b0, torque_reach_reference} + {1'b0, torque_reach_release_offset};
    end

    // ------------------------------------------------------------
    // Supervisory flags
    // ------------------------------------------------------------
    // Qualify timer counts whole milliseconds of continuous overspeed
    always_comb begin
        next_qual_tick = qual_tick;
        next_qual_ms = qual_ms;
        next_speed_limited_output = speed_limited_output;
        if (!drive.torque_mode || !over_limit) begin
            next_qual_tick = '0;
            next_qual_ms = '0;
            next_speed_limited_output = 1'b0;
        end else if (qual_ms >= speed_limited_qualify_time) begin
            next_speed_limited_output = 1'b1;
        end else if (qual_tick == 32'(QUAL_TICK_CYCLES - 1)) begin
            next_qual_tick = '0;
            next_qual_ms = qual_ms + 16'h0001;
        end else begin
            next_qual_tick = qual_tick + 32'h0000_0001;
        end
        // Hysteresis: between thresholds the flag keeps its state
        next_torque_reach_output = torque_reach_output;
        if ({1'b0, abs_torque} >= reach_on) begin
            next_torque_reach_output = 1'b1;
        end else if ({1'b0, abs_torque} < reach_off) begin
            next_torque_reach_output = 1'b0;
        end
        next_actual_torque_reference_monitor = abs_torque;
        next_limit.pos_limit = lim_pos;
        next_limit.neg_limit = lim_neg;
        next_limit.active = drive.torque_mode;
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    // Address and data are latched separately so either may come first
    assign write_go = have_aw && have_w && !s_axi_bvalid;

    // Clamp a written value to the largest legal setting
    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] mx);
        clamp = (v > mx) ? mx : v;
    endfunction

    always_comb begin
        logic [15:0] wv;
        wv = w_data[15:0];
        next_have_aw = have_aw;
        next_have_w = have_w;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_awready = 1'b0;
        next_wready = 1'b0;
        next_bvalid = s_axi_bvalid;
        next_bresp = s_axi_bresp;
        next_arready = 1'b0;
        next_rvalid = s_axi_rvalid;
        next_rresp = s_axi_rresp;
        next_rdata = s_axi_rdata;
        next_speed_limit_source_select = speed_limit_source_select;
        next_positive_speed_limit = positive_speed_limit;
        next_negative_speed_limit = negative_speed_limit;
        next_torque_reach_reference = torque_reach_reference;
        next_torque_reach_assert_offset = torque_reach_assert_offset;
        next_torque_reach_release_offset = torque_reach_release_offset;
        next_speed_limited_qualify_time = speed_limited_qualify_time;
        // Ready is a one-cycle pulse while the holding slot is empty
        if (s_axi_awvalid && !have_aw && !s_axi_awready) begin
            next_awready = 1'b1;
            next_have_aw = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !have_w && !s_axi_wready) begin
            next_wready = 1'b1;
            next_have_w = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (write_go) begin
            next_have_aw = 1'b0;
            next_have_w = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = AXI_OKAY;
            // Partial writes are ignored: fields are 16 bits, low lanes both required
            if (w_strb[1:0] == 2'b11) begin
                case (aw_addr)
                    OFF_SOURCE_SELECT: next_speed_limit_source_select = wv;
                    OFF_POS_LIMIT: next_positive_speed_limit = clamp(wv, SPEED_LIMIT_MAX);
                    OFF_NEG_LIMIT: next_negative_speed_limit = clamp(wv, SPEED_LIMIT_MAX);
                    OFF_REACH_REF: next_torque_reach_reference = clamp(wv, TORQUE_PCT_MAX);
                    OFF_REACH_ASSERT: begin
                        next_torque_reach_assert_offset = clamp(wv, TORQUE_PCT_MAX);
                    end
                    OFF_REACH_RELEASE: begin
                        next_torque_reach_release_offset = clamp(wv, TORQUE_PCT_MAX);
                    end
                    OFF_QUALIFY_TIME: next_speed_limited_qualify_time = wv;
                    OFF_STATUS, OFF_TORQUE_MON, OFF_ACTIVE_LIMIT, OFF_CONTROL: begin
                        next_bresp = AXI_OKAY;
                    end
                    default: next_bresp = AXI_SLVERR;
                endcase
            end
        end else if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        // Read path: one read in flight
        if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                next_rvalid = 1'b0;
            end
        end else if (s_axi_arvalid && !s_axi_arready) begin
            next_arready = 1'b1;
            next_rvalid = 1'b1;
            next_rresp = AXI_OKAY;
            next_rdata = '0;
            case (s_axi_araddr)
                OFF_SOURCE_SELECT: next_rdata[15:0] = speed_limit_source_select;
                OFF_POS_LIMIT: next_rdata[15:0] = positive_speed_limit;
                OFF_NEG_LIMIT: next_rdata[15:0] = negative_speed_limit;
                OFF_REACH_REF: next_rdata[15:0] = torque_reach_reference;
                OFF_REACH_ASSERT: next_rdata[15:0] = torque_reach_assert_offset;
                OFF_REACH_RELEASE: next_rdata[15:0] = torque_reach_release_offset;
                OFF_QUALIFY_TIME: next_rdata[15:0] = speed_limited_qualify_time;
                OFF_CONTROL: next_rdata[CTRL_TORQUE_MODE_BIT] = drive.torque_mode;
                OFF_STATUS: begin
                    next_rdata[STAT_SPEED_LIMITED_BIT] = speed_limited_output;
                    next_rdata[STAT_TORQUE_REACH_BIT] = torque_reach_output;
                    next_rdata[STAT_SEL_INPUT_BIT] = drive.limit_select_input;
                end
                OFF_TORQUE_MON: next_rdata[15:0] = actual_torque_reference_monitor;
                OFF_ACTIVE_LIMIT: next_rdata = {limit.neg_limit, limit.pos_limit};
                default: next_rresp = AXI_SLVERR;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            speed_limit_source_select <= RST_SOURCE_SELECT;
            positive_speed_limit <= RST_POS_LIMIT;
            negative_speed_limit <= RST_NEG_LIMIT;
            torque_reach_reference <= RST_REACH_REF;
            torque_reach_assert_offset <= RST_REACH_ASSERT;
            torque_reach_release_offset <= RST_REACH_RELEASE;
            speed_limited_qualify_time <= RST_QUALIFY_TIME;
            actual_torque_reference_monitor <= '0;
            qual_ms <= '0;
            qual_tick <= '0;
            speed_limited_output <= 1'b0;
            torque_reach_output <= 1'b0;
            limit <= '0;
            have_aw <= 1'b0;
            have_w <= 1'b0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AXI_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp <= AXI_OKAY;
            s_axi_rdata <= '0;
        end else begin
            speed_limit_source_select <= next_speed_limit_source_select;
            positive_speed_limit <= next_positive_speed_limit;
            negative_speed_limit <= next_negative_speed_limit;
            torque_reach_reference <= next_torque_reach_reference;
            torque_reach_assert_offset <= next_torque_reach_assert_offset;
            torque_reach_release_offset <= next_torque_reach_release_offset;
            speed_limited_qualify_time <= next_speed_limited_qualify_time;
            actual_torque_reference_monitor <= next_actual_torque_reference_monitor;
            qual_ms <= next_qual_ms;
            qual_tick <= next_qual_tick;
            speed_limited_output <= next_speed_limited_output;
            torque_reach_output <= next_torque_reach_output;
            limit <= next_limit;
            have_aw <= next_have_aw;
            have_w <= next_have_w;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready <= next_wready;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_arready <= next_arready;
            s_axi_rvalid <= next_rvalid;
            s_axi_rresp <= next_rresp;
            s_axi_rdata <= next_rdata;
        end
    end
endmodule

// file: inc/tqsl_pkg.sv
// Package for the torque-mode speed limit and torque reach block
package tqsl_pkg;
    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_SOURCE_SELECT = 8'h00;
    localparam logic [7:0] OFF_POS_LIMIT = 8'h04;
    localparam logic [7:0] OFF_NEG_LIMIT = 8'h08;
    localparam logic [7:0] OFF_REACH_REF = 8'h0C;
    localparam logic [7:0] OFF_REACH_ASSERT = 8'h10;
    localparam logic [7:0] OFF_REACH_RELEASE = 8'h14;
    localparam logic [7:0] OFF_QUALIFY_TIME = 8'h18;
    localparam logic [7:0] OFF_CONTROL = 8'h1C;
    localparam logic [7:0] OFF_STATUS = 8'h20;
    localparam logic [7:0] OFF_TORQUE_MON = 8'h24;
    localparam logic [7:0] OFF_ACTIVE_LIMIT = 8'h28;
    // ------------------------------------------------------------
    // Field positions and values
    // ------------------------------------------------------------
    localparam int CTRL_TORQUE_MODE_BIT = 0;
    localparam int STAT_SPEED_LIMITED_BIT = 0;
    localparam int STAT_TORQUE_REACH_BIT = 1;
    localparam int STAT_SEL_INPUT_BIT = 2;
    localparam logic [15:0] SRC_INTERNAL = 16'h0000;
    localparam logic [15:0] SRC_RESERVED = 16'h0001;
    localparam logic [15:0] SRC_BY_INPUT = 16'h0002;
    localparam logic [15:0] SPEED_LIMIT_MAX = 16'h1770;
    localparam logic [15:0] TORQUE_PCT_MAX = 16'h0BB8;
    localparam logic [15:0] TORQUE_PCT_RATED = 16'h03E8;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_SOURCE_SELECT = 16'h0000;
    localparam logic [15:0] RST_POS_LIMIT = 16'h0BB8;
    localparam logic [15:0] RST_NEG_LIMIT = 16'h0BB8;
    localparam logic [15:0] RST_REACH_REF = 16'h0000;
    localparam logic [15:0] RST_REACH_ASSERT = 16'h00C8;
    localparam logic [15:0] RST_REACH_RELEASE = 16'h0064;
    localparam logic [15:0] RST_QUALIFY_TIME = 16'h000A;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int QUAL_TICK_NS = 1000000;
    localparam int QUAL_TICK_CYCLES = QUAL_TICK_NS / CLK_PERIOD_NS;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;

    // Drive-side samples that travel together
    typedef struct packed {
        logic torque_mode;
        logic limit_select_input;
        logic signed [15:0] motor_speed;
        logic signed [15:0] torque_reference;
    } tqsl_drive_s;

    // Limits handed to the speed loop
    typedef struct packed {
        logic [15:0] pos_limit;
        logic [15:0] neg_limit;
        logic active;
    } tqsl_limit_s;
endpackage

// file: verif/tqsl_monitor.sv
// Checker for the speed limit and torque reach block
`timescale 1ns/1ps
module tqsl_monitor (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register writes
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    // Drive side
    input wire tqsl_pkg::tqsl_drive_s drive,
    input wire tqsl_pkg::tqsl_limit_s limit,
    input wire logic speed_limited_output,
    input wire logic torque_reach_output
);
    import tqsl_pkg::*;
    logic [15:0] sh [0:7];
    logic [15:0] abs_spd, abs_tq, lim, exp_pos, exp_neg;
    logic [16:0] on_lvl, off_lvl;
    logic over, t_on, t_off;
    logic [31:0] run;
    // ----
    // Shadow registers, stored on the design's write edge
    // ----
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sh <= '{16'h0, 16'h0BB8, 16'h0BB8, 16'h0, 16'h00C8, 16'h0064, 16'hA, 16'h0};
        end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
            && s_axi_awaddr < OFF_CONTROL && s_axi_wstrb[1:0] == 2'b11) begin
            sh[s_axi_awaddr[4:2]] <= s_axi_wdata[15:0];
        end
    end
    // Expected limits; above-range writes are not modelled
    always_comb begin
        exp_pos = sh[1];
        exp_neg = sh[2];
        if (sh[0] == SRC_BY_INPUT) begin
            exp_pos = drive.limit_select_input ? sh[2] : sh[1];
            exp_neg = exp_pos;
        end
        abs_spd = drive.motor_speed[15] ? -drive.motor_speed : drive.motor_speed;
        abs_tq = drive.torque_reference[15] ? -drive.torque_reference : drive.torque_reference;
        lim = drive.motor_speed[15] ? exp_neg : exp_pos;
        over = drive.torque_mode && abs_spd > lim;
        on_lvl = {1'b0, sh[3]} + {1'b0, sh[4]};
        off_lvl = {1'b0, sh[3]} + {1'b0, sh[5]};
        t_on = {1'b0, abs_tq} >= on_lvl;
        t_off = {1'b0, abs_tq} < off_lvl;
    end
    // Overspeed run length; restarts once speed is within the limit
    always_ff @(posedge aclk) begin
        if (!aresetn || !over) run <= '0;
        else run <= run + 32'h1;
    end
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_limit_mode: assert property (
        $past(aresetn) |-> limit.active == $past(drive.torque_mode)) else $error("limit flag");
    a_limit_pair: assert property (
        $past(aresetn) && limit.active |-> limit.pos_limit == $past(exp_pos)
        && limit.neg_limit == $past(exp_neg)) else $error("limit pair");
    a_reach_set: assert property (
        $past(aresetn) && $past(t_on) |-> torque_reach_output) else $error("reach not set");
    a_reach_clear: assert property (
        $past(aresetn) && $past(t_off) |-> !torque_reach_output) else $error("reach not clear");
    a_reach_band_hold: assert property (
        $past(aresetn) && $past(!t_on && !t_off) |-> $stable(torque_reach_output))
        else $error("reach moved in band");
    a_slim_mode: assert property (
        $past(aresetn) && !$past(drive.torque_mode) |-> !speed_limited_output)
        else $error("speed flag outside torque mode");
    a_slim_below: assert property (
        $past(aresetn) && !$past(over) |-> !speed_limited_output) else $error("speed flag early");
    a_slim_qualify: assert property (
        $rose(speed_limited_output) |-> $past(run) >= 32'(sh[6]) * QUAL_TICK_CYCLES)
        else $error("speed flag before qualify time");
    a_slim_prompt: assert property (
        sh[6] == 16'h0000 && $past(aresetn) && $past(over) |-> speed_limited_output)
        else $error("speed flag late");
    c_reach: cover property ($rose(torque_reach_output));
    c_slim: cover property ($rose(speed_limited_output));
    c_sel: cover property (limit.active && sh[0] == SRC_BY_INPUT && drive.limit_select_input);
endmodule
bind tqsl_top tqsl_monitor i_mon (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .drive,
    .limit, .speed_limited_output, .torque_reach_output);

// file: verif/tqsl_host_model.sv
// Host controller model that produces the drive samples
`timescale 1ns/1ps
module tqsl_host_model (
    // Clock
    input wire logic aclk,
    // Requested levels
    input wire logic mode,
    input wire logic raw_sel,
    input wire logic sel_low,
    input wire logic signed [15:0] speed,
    input wire logic signed [15:0] torque,
    // Samples to the block
    output tqsl_pkg::tqsl_drive_s drive
);
    import tqsl_pkg::*;
    initial drive = '0;
    // Pin level turned into the select state by its polarity
    always @(posedge aclk) begin
        drive <= '{mode, raw_sel ^ sel_low, speed, torque};
    end
endmodule

// file: verif/tqsl_top_bench.sv
// Self-checking bench for the speed limit and torque reach block
`timescale 1ns/1ps
module tqsl_top_bench;
    import tqsl_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, speed_limited_output, torque_reach_output, h_mode, h_raw, h_low;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic signed [15:0] h_spd, h_tq;
    tqsl_drive_s drive;
    tqsl_limit_s limit;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;
    tqsl_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .drive, .limit, .speed_limited_output,
        .torque_reach_output);
    tqsl_host_model i_host (.aclk, .mode(h_mode), .raw_sel(h_raw), .sel_low(h_low),
        .speed(h_spd), .torque(h_tq), .drive);
    // ----
    // Shared tasks
    // ----
    task automatic check(input bit ok, input string msg);
        comparisons++;
        if (!ok) begin
            errors++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask
    task automatic finish_test;
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Address and data offered together, each dropped once taken
    task automatic axi_wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
        int n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && n < 50);
        s_axi_bready <= 1'b0;
        check(s_axi_bresp === er, "write response");
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (s_axi_rvalid !== 1'b1 && n < 50);
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b0;
        check(s_axi_rdata === ed && s_axi_rresp === er, "read data");
    endtask
    // Host levels, then a cycle each in model and block
    task automatic set_drv(input logic m, r, lo, input logic [15:0] s, t);
        @(posedge aclk);
        h_mode <= m;
        h_raw <= r;
        h_low <= lo;
        h_spd <= s;
        h_tq <= t;
        repeat (3) @(posedge aclk);
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_regs;
        logic [15:0] rv [0:6] = '{16'h0, 16'h0BB8, 16'h0BB8, 16'h0, 16'h00C8, 16'h0064, 16'h000A};
        for (int i = 0; i < 7; i++) axi_rd(8'(4 * i), {16'h0, rv[i]}, AXI_OKAY);
        axi_rd(8'h40, 32'h0, AXI_SLVERR);
        axi_wr(8'h40, 16'h0001, AXI_SLVERR);
        axi_wr(OFF_TORQUE_MON, 16'h1234, AXI_OKAY);
        axi_rd(OFF_TORQUE_MON, 32'h0, AXI_OKAY);
        $display("test regs done");
    endtask
    task automatic t_source;
        logic [15:0] ep, en;
        axi_wr(OFF_POS_LIMIT, 16'h03E8, AXI_OKAY);
        axi_wr(OFF_NEG_LIMIT, 16'h07D0, AXI_OKAY);
        for (int s = 0; s < 3; s++) begin
            axi_wr(OFF_SOURCE_SELECT, 16'(s), AXI_OKAY);
            for (int k = 0; k < 2; k++) begin
                set_drv(1'b1, k[0], 1'b0, 16'h0, 16'h0);
                ep = (s == 2 && k == 1) ? 16'h07D0 : 16'h03E8;
                en = (s == 2) ? ep : 16'h07D0;
                check(limit === {ep, en, 1'b1}, "limit pair");
                axi_rd(OFF_ACTIVE_LIMIT, {en, ep}, AXI_OKAY);
            end
        end
        set_drv(1'b1, 1'b0, 1'b1, 16'h0, 16'h0);
        check(limit.pos_limit === 16'h07D0, "active low select");
        set_drv(1'b0, 1'b0, 1'b0, 16'h0, 16'h0);
        check(limit.active === 1'b0, "limit outside torque mode");
        axi_wr(OFF_SOURCE_SELECT, 16'h0000, AXI_OKAY);
        $display("test source done");
    endtask
    task automatic t_reach;
        logic [15:0] tq [0:6] = '{16'hFD76, 16'hFD44, 16'h28A, 16'h258, 16'h257, 16'h2BB, 16'h2BC};
        logic [0:6] er = 7'b0111001;
        axi_wr(OFF_REACH_REF, 16'h01F4, AXI_OKAY);
        for (int i = 0; i < 7; i++) begin
            set_drv(1'b1, 1'b1, 1'b0, 16'h0, tq[i]);
            check(torque_reach_output === er[i], "torque reach");
        end
        axi_rd(OFF_TORQUE_MON, 32'h2BC, AXI_OKAY);
        axi_rd(OFF_STATUS, 32'h6, AXI_OKAY);
        axi_rd(OFF_CONTROL, 32'h1, AXI_OKAY);
        $display("test reach done");
    endtask
    task automatic t_slim;
        logic [15:0] sp [0:5] = '{16'h03E8, 16'h03E9, 16'hF830, 16'hF82F, 16'hF82F, 16'h0};
        logic [0:5] md = 6'b111101;
        logic [0:5] ex = 6'b010100;
        int n = 0;
        axi_wr(OFF_QUALIFY_TIME, 16'h0, AXI_OKAY);
        for (int i = 0; i < 6; i++) begin
            set_drv(md[i], 1'b0, 1'b0, sp[i], 16'h0);
            check(speed_limited_output === ex[i], "speed flag");
        end
        axi_wr(OFF_QUALIFY_TIME, 16'h1, AXI_OKAY);
        set_drv(1'b1, 1'b0, 1'b0, 16'h05DC, 16'h0);
        repeat (49000) @(posedge aclk);
        check(speed_limited_output === 1'b0, "speed flag early");
        while (speed_limited_output !== 1'b1 && n < 2000) begin
            @(posedge aclk);
            n++;
        end
        check(n < 2000, "speed flag late");
        axi_rd(OFF_STATUS, 32'h1, AXI_OKAY);
        set_drv(1'b1, 1'b0, 1'b0, 16'h0, 16'h0);
        set_drv(1'b1, 1'b0, 1'b0, 16'h05DC, 16'h0);
        check(speed_limited_output === 1'b0, "timer restart");
        $display("test speed limited done");
    endtask
    // ----
    // Clock, reset, sequence and timeout
    // ----
    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hF;
        {h_mode, h_raw, h_low, h_spd, h_tq} = '0;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs;
        t_source;
        t_reach;
        t_slim;
        finish_test;
    end
    // Expected run is about 50300 cycles
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            errors++;
            $display("[ERR] %0t timeout", $time);
            finish_test;
        end
    end
endmodule
